// ### hw/modem_regs.sv
// modem status register, extra-feature select, scratch, divisor latches and level counters
//
// How it works
// - status read-only; writes there go to select
// - reading status clears the four change bits
// - bit 7 is inverted cd, loopback out2
// - bit 6 is inverted ri, loopback out1
// - bit 5 is inverted dsr, loopback dtr
// - bit 4 is inverted cts, loopback rts
// - bit 3 sets on any cd change
// - bit 2 sets only on ri rising
// - bit 1 sets on any dsr change
// - bit 0 sets on any cts change
// - modem interrupt while any change bit set
// - select bits 2:1 choose visible register set
// - select bit 0 enables level counter reads
// - counters reachable only when set is general
// - scratch byte is plain read/write storage
// - two latches form a 16-bit baud divisor
// - tx count reports free transmit entries
// - rx count reports receive characters held
`include "modem_regs_params.svh"
`timescale 1ns/1ps
`default_nettype none

module modem_regs
	import modem_regs_pkg::*;
#(
	parameter int COUNT_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// register port
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	// modem control inputs, active low pins
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic cd_n,
	// fifo levels from the datapath
	input wire logic [COUNT_W-1:0] tx_space,
	input wire logic [COUNT_W-1:0] rx_fill,
	// outputs to the rest of the channel
	output logic modem_irq,
	output logic [15:0] baud_divisor,
	output logic [1:0] reg_set,
	output logic [7:0] modem_control_reg
);

	// the read mux widens the counters to one byte, so wider counts cannot be shown
	if (COUNT_W < 1 || COUNT_W > 8) begin : g_bad_count_w
		$error("COUNT_W must be 1 to 8");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] select_ff;
	logic [7:0] scratch_ff;
	logic [7:0] div_low_ff;
	logic [7:0] div_high_ff;
	logic [7:0] mcr_ff;
	logic [7:0] rdata_ff;
	// modem inputs as {cd, ri, dsr, cts}, pin polarity
	logic [3:0] sync1_ff;
	logic [3:0] sync2_ff;
	logic [3:0] prev_ff;
	logic [3:0] delta_ff;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
		hit = (a == ofs);
	endfunction

	wire logic set_general_sel = (select_ff[`SEL_SET_MSB:`SEL_SET_LSB] == set_general);
	// the set select outranks the counter enable
	wire logic lvl_visible = select_ff[`SEL_LVL_EN_BIT] && set_general_sel;
	wire logic wr_select = wr && hit(addr, `OFS_STATUS_SELECT);
	wire logic wr_scratch = wr && hit(addr, `OFS_SCRATCH);
	wire logic wr_div_low = wr && hit(addr, `OFS_DIV_LOW);
	wire logic wr_div_high = wr && hit(addr, `OFS_DIV_HIGH);
	wire logic wr_mcr = wr && hit(addr, `OFS_MODEM_CTRL);
	wire logic rd_status = rd && hit(addr, `OFS_STATUS_SELECT);

	// ----------------------------------------------------------------
	// modem status
	// ----------------------------------------------------------------
	wire logic loopback = mcr_ff[`MCR_LOOP_BIT];
	wire logic [3:0] live_level;
	assign live_level[3] = loopback ? mcr_ff[`MCR_OUT2_BIT] : ~sync2_ff[3];
	assign live_level[2] = loopback ? mcr_ff[`MCR_OUT1_BIT] : ~sync2_ff[2];
	assign live_level[1] = loopback ? mcr_ff[`MCR_DTR_BIT] : ~sync2_ff[1];
	assign live_level[0] = loopback ? mcr_ff[`MCR_RTS_BIT] : ~sync2_ff[0];

	// changes are taken on the pins themselves so loopback does not fake edges
	wire logic [3:0] change = sync2_ff ^ prev_ff;
	wire logic [3:0] delta_set;
	assign delta_set[3] = change[3];
	assign delta_set[2] = change[2] && sync2_ff[2];
	assign delta_set[1] = change[1];
	assign delta_set[0] = change[0];
	// a fresh change in the read cycle survives the clear
	wire logic [3:0] nxt_delta = delta_set | (rd_status ? `RST_DELTA : delta_ff);

	wire logic [7:0] status_byte = {live_level, delta_ff};

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	wire logic [7:0] tx_byte = 8'(tx_space);
	wire logic [7:0] rx_byte = 8'(rx_fill);
	logic [7:0] nxt_rdata;
	always_comb begin
		if (hit(addr, `OFS_STATUS_SELECT)) begin
			nxt_rdata = status_byte;
		end else if (hit(addr, `OFS_SCRATCH)) begin
			nxt_rdata = scratch_ff;
		end else if (hit(addr, `OFS_DIV_LOW)) begin
			nxt_rdata = div_low_ff;
		end else if (hit(addr, `OFS_DIV_HIGH)) begin
			nxt_rdata = div_high_ff;
		end else if (hit(addr, `OFS_TX_SPACE)) begin
			nxt_rdata = lvl_visible ? tx_byte : `RST_BYTE;
		end else if (hit(addr, `OFS_RX_FILL)) begin
			nxt_rdata = lvl_visible ? rx_byte : `RST_BYTE;
		end else if (hit(addr, `OFS_MODEM_CTRL)) begin
			nxt_rdata = mcr_ff;
		end else begin
			nxt_rdata = `RST_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// flops
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sync1_ff <= `RST_MODEM_IN;
			sync2_ff <= `RST_MODEM_IN;
			prev_ff <= `RST_MODEM_IN;
		end else begin
			sync1_ff <= {cd_n, ri_n, dsr_n, cts_n};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			delta_ff <= `RST_DELTA;
		end else begin
			delta_ff <= nxt_delta;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			select_ff <= `RST_BYTE;
			scratch_ff <= `RST_BYTE;
			mcr_ff <= `RST_BYTE;
		end else begin
			if (wr_select) begin
				select_ff <= {5'h00, wdata[`SEL_SET_MSB:0]};
			end
			if (wr_scratch) begin
				scratch_ff <= wdata;
			end
			if (wr_mcr) begin
				mcr_ff <= wdata;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			div_low_ff <= `RST_BYTE;
			div_high_ff <= `RST_BYTE;
		end else begin
			if (wr_div_low) begin
				div_low_ff <= wdata;
			end
			if (wr_div_high) begin
				div_high_ff <= wdata;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= `RST_BYTE;
		end else if (rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= `RST_BYTE;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rdata = rdata_ff;
	assign modem_irq = |delta_ff;
	assign baud_divisor = {div_high_ff, div_low_ff};
	assign reg_set = select_ff[`SEL_SET_MSB:`SEL_SET_LSB];
	assign modem_control_reg = mcr_ff;

endmodule

`default_nettype wire

// ### hw/modem_regs_params.svh
// register offsets, field positions and reset values of the modem status and select block
`ifndef MODEM_REGS_PARAMS_SVH
`define MODEM_REGS_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets (3-bit address)
// ----------------------------------------------------------------
`define OFS_STATUS_SELECT 3'h6
`define OFS_SCRATCH 3'h7
`define OFS_DIV_LOW 3'h0
`define OFS_DIV_HIGH 3'h1
`define OFS_TX_SPACE 3'h2
`define OFS_RX_FILL 3'h3
`define OFS_MODEM_CTRL 3'h4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SEL_LVL_EN_BIT 0
`define SEL_SET_LSB 1
`define SEL_SET_MSB 2
`define MCR_DTR_BIT 0
`define MCR_RTS_BIT 1
`define MCR_OUT1_BIT 2
`define MCR_OUT2_BIT 3
`define MCR_LOOP_BIT 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_MODEM_IN 4'hf
`define RST_DELTA 4'h0

`endif

// ### hw/modem_regs_pkg.sv
// types of the modem status and register select block
package modem_regs_pkg;
	typedef enum logic [1:0] {
		set_general = 2'h0,
		set_extra_one = 2'h1,
		set_extra_two = 2'h2,
		set_reserved = 2'h3
	} reg_set_e;
endpackage

// ### test/modem_regs_assertions.sv
// checker of the modem status and register select block
`timescale 1ns/1ps
`default_nettype none
module modem_regs_assertions (
	// bus side
	input wire logic clock, rstn, wr, rd,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata, rdata, modem_control_reg,
	// modem side and outputs
	input wire logic cts_n, dsr_n, ri_n, cd_n, modem_irq,
	input wire logic [1:0] reg_set
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	logic [2:0] calm_ff;
	// a read clear is judged only once the pin pipeline has settled
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) calm_ff <= 3'h0;
		else if ($changed({cts_n, dsr_n, ri_n, cd_n})) calm_ff <= 3'h0;
		else if (calm_ff != 3'h7) calm_ff <= calm_ff + 3'h1;
	end
	sel_write_a: assert property (wr && addr == 3'h6 |=>
		reg_set == $past(wdata[2:1]) && $stable(modem_control_reg)) else $error("select write lost");
	cts_change_a: assert property ($changed(cts_n) |-> ##[2:4] modem_irq)
		else $error("cts change missed");
	dsr_change_a: assert property ($changed(dsr_n) |-> ##[2:4] modem_irq)
		else $error("dsr change missed");
	cd_change_a: assert property ($changed(cd_n) |-> ##[2:4] modem_irq)
		else $error("cd change missed");
	ri_rise_a: assert property ($rose(ri_n) |-> ##[2:4] modem_irq)
		else $error("ri rise missed");
	read_clear_a: assert property (rd && addr == 3'h6 && calm_ff == 3'h7 |=> !modem_irq)
		else $error("read did not clear");
	count_gate_a: assert property (rd && addr[2:1] == 2'h1 && reg_set != 2'h0 |=> rdata == 8'h00)
		else $error("counter leaked");
	rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
		else $error("read data not idle");
	cover property (rd && addr == 3'h6 && modem_irq);
	cover property ($rose(ri_n));
	cover property (wr && addr == 3'h6 && wdata[2:1] != 2'h0);
endmodule
bind modem_regs modem_regs_assertions chk (.clock, .rstn, .wr, .rd, .addr, .wdata, .rdata,
	.modem_control_reg, .cts_n, .dsr_n, .ri_n, .cd_n, .modem_irq, .reg_set);
`default_nettype wire

// ### test/modem_peer.sv
// modem peer that drives the active low status pins
`timescale 1ns/1ps
`default_nettype none
module modem_peer (
	// clock and commanded levels {cd, ri, dsr, cts}
	input wire logic clock,
	input wire logic [3:0] want,
	// pins
	output logic cts_n, dsr_n, ri_n, cd_n
);
	// pins move only on an edge, as a real modem behind a synchroniser would look
	always_ff @(posedge clock) {cd_n, ri_n, dsr_n, cts_n} <= want;
endmodule
`default_nettype wire

// ### test/test_uart_modem_status_and_regselect.sv
// random and corner tests of the modem status and select block
`timescale 1ns/1ps
`default_nettype none
module test_uart_modem_status_and_regselect;
	logic clock = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, tx_space = 8'h00, rx_fill = 8'h00, ex;
	logic [3:0] want = 4'hf, pins = 4'hf;
	logic [31:0] r = 32'h742c;
	wire logic cts_n, dsr_n, ri_n, cd_n, modem_irq;
	wire logic [7:0] rdata, modem_control_reg;
	wire logic [15:0] baud_divisor;
	wire logic [1:0] reg_set;
	int mismatches = 0, checks_done = 0;
	// ----------------
	// parts and helpers
	// ----------------
	initial forever #12.5 clock = ~clock;
	modem_peer peer (.clock, .want, .cts_n, .dsr_n, .ri_n, .cd_n);
	modem_regs dut (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .cts_n, .dsr_n, .ri_n,
		.cd_n, .tx_space, .rx_fill, .modem_irq, .baud_divisor, .reg_set, .modem_control_reg);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// ri flags only its pin going high; the others flag either edge
	function automatic logic [7:0] status(input logic [3:0] o, input logic [3:0] p);
		return {~p, p[3] ^ o[3], p[2] & ~o[2], p[1] ^ o[1], p[0] ^ o[0]};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic put(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic get(input logic [2:0] a, input logic [7:0] e, input string n);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		chk(n, {8'h00, e}, {8'h00, rdata});
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ----------------
	// tests
	// ----------------
	initial begin
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		get(3'h6, 8'h00, "status at reset");
		get(3'h5, 8'h00, "unmapped");
		for (int i = 0; i < 4; i++) begin
			r = lfsr(r);
			put(3'h7, r[7:0]);
			put(3'h0, r[15:8]);
			put(3'h1, r[23:16]);
			get(3'h7, r[7:0], "scratch");
			get(3'h0, r[15:8], "div low");
			get(3'h1, r[23:16], "div high");
			chk("divisor", r[23:8], baud_divisor);
		end
		$display("storage test done");
		for (int i = 0; i < 10; i++) begin
			r = lfsr(r);
			want <= r[3:0];
			repeat (6) @(negedge clock);
			ex = status(pins, r[3:0]);
			chk("irq", {15'h0, |ex[3:0]}, {15'h0, modem_irq});
			get(3'h6, ex, "status");
			get(3'h6, {ex[7:4], 4'h0}, "status again");
			pins = r[3:0];
			put(3'h4, {4'h1, r[11:8]});
			get(3'h6, {r[11], r[10], r[8], r[9], 4'h0}, "loopback");
			chk("modem ctrl", {8'h00, 4'h1, r[11:8]}, {8'h00, modem_control_reg});
			put(3'h4, 8'h00);
		end
		$display("modem test done");
		for (int s = 0; s < 8; s++) begin
			r = lfsr(r);
			tx_space <= r[7:0];
			rx_fill <= r[15:8];
			put(3'h6, {r[23:19], s[2:0]});
			@(negedge clock);
			chk("set", {14'h0, s[2:1]}, {14'h0, reg_set});
			get(3'h2, (s == 1) ? r[7:0] : 8'h00, "tx space");
			get(3'h3, (s == 1) ? r[15:8] : 8'h00, "rx fill");
		end
		$display("select test done");
		final_report;
	end
	initial begin
		repeat (4000) @(posedge clock);
		mismatches++;
		final_report;
	end
endmodule
`default_nettype wire
